/* File: irc_readout_chain.sv */
// Readout and mode sequencing of an eight-channel integrating converter.
// Assumes a host that drives integration_control and shift_clock and keeps its timing windows.
// Function
// - Fall back to gapped mode when integration ends before measure-reset-autozero finishes.
// - On fallback, measure both sides shorted, then start gapped integration.
// - Return to seamless once periods cover measure-reset-autozero; first may be shorter.
// - Word-length select high gives 20-bit words, low drops four LSBs.
// - Offset binary: zero maps to 0x01000, saturate at all ones, clip at zero.
// - Newest results become readable when data_ready_n falls, in both modes.
// - Each next serial bit appears on a falling shift_clock edge.
// - A falling shift_clock edge drives data_ready_n high again.
// - First serial bit valid a fixed lead time before data_ready_n falls.
// - Chain input bits follow this device's own words on the serial output.
// - 160 shift periods per device with 20-bit words, 128 with 16-bit.
// - 16-bit words shorten readout by one fifth.
// - First integration_control pulse after reset ends release and starts integration.
// - data_ready_n stays low until shift_clock goes high then low.
// - integration_control during measure-reset-autozero forces gapped mode; it is ignored in the gapped wait.
// - After power-up the sequencer always starts in gapped operation.
`timescale 1ns/1ps
`default_nettype none

module irc_readout_chain
  import irc_pkg::*;
#(
  parameter int INTEGRATION_CONTROL_CYC = INTEGRATION_CONTROL_CYC_DEF,
  parameter int INTEGRATION_CONTROL_FAST_CYC = INTEGRATION_CONTROL_FAST_CYC_DEF,
  parameter int MRAZ_CYC = MRAZ_CYC_DEF,
  parameter int MRAZ_FAST_CYC = MRAZ_FAST_CYC_DEF
) (
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host pins
  input wire logic shift_clock,
  input wire logic integration_control,
  input wire logic word_select_20,
  input wire logic fast_timing_sel,
  input wire logic chain_in,
  output logic serial_out,
  output logic data_ready_n,
  // Front end
  input wire irc_results_t results,
  output logic integrating_side,
  output logic input_shorted,
  output logic seamless_mode
);

  irc_core_t c_ff;
  irc_core_t nxt_c;
  irc_link_t l_ff;
  irc_link_t nxt_l;

  logic [CNT_W-1:0] integration_control_c;
  logic [CNT_W-1:0] mraz_c;
  logic [CNT_W-1:0] lead_c;
  logic [CNT_W-1:0] rd_at;
  logic [CNT_W-1:0] wr_at;
  logic [CNT_W-1:0] commit_at;
  logic [CNT_W-1:0] wr_off;
  logic [CNT_W-1:0] rd_off;
  logic ctl_ev;
  logic edge_ev;
  logic mraz_done;
  logic wr_phase;
  logic shift_phase;
  logic new_frame;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] wr_word;

  // Offset-binary code from a signed raw value, clipped at both ends
  function automatic logic [WORD_W-1:0] to_code(input logic [RAW_W-1:0] raw);
    logic signed [RAW_W:0] sum;
    logic signed [RAW_W:0] top;
    sum = $signed({raw[RAW_W-1], raw}) + $signed({{(RAW_W + 1 - WORD_W){1'b0}}, CODE_ZERO});
    top = $signed({{(RAW_W + 1 - WORD_W){1'b0}}, CODE_MAX});
    if (sum < 0) begin
      return CODE_MIN;
    end else if (sum > top) begin
      return CODE_MAX;
    end
    return sum[WORD_W-1:0];
  endfunction

  // Timing set picked by the fast-setting pin
  assign integration_control_c = c_ff.fast_lvl ? CNT_W'(INTEGRATION_CONTROL_FAST_CYC) : CNT_W'(INTEGRATION_CONTROL_CYC);
  assign mraz_c = c_ff.fast_lvl ? CNT_W'(MRAZ_FAST_CYC) : CNT_W'(MRAZ_CYC);
  assign lead_c = c_ff.fast_lvl ? LEAD_FAST_CYC : LEAD_CYC;

  // Build window: eight writes, eight reads, frame complete lead cycles before ready
  assign commit_at = integration_control_c - lead_c - CNT_ONE;
  assign rd_at = commit_at - BUILD_SLOTS;
  assign wr_at = rd_at - BUILD_SLOTS;
  assign wr_off = c_ff.mraz_cnt - wr_at;
  assign rd_off = c_ff.mraz_cnt - rd_at;
  assign wr_phase = c_ff.busy && (c_ff.mraz_cnt >= wr_at) && (wr_off < BUILD_SLOTS);
  assign shift_phase = c_ff.busy && (c_ff.mraz_cnt > rd_at) && (rd_off <= BUILD_SLOTS);
  assign wr_word = to_code(results.raw[wr_off[CH_AW-1:0]]);

  // Control event once its synchroniser stages agree; shift edge on any change of the synchronised toggle
  assign ctl_ev = (c_ff.ctl_sync[2] == c_ff.ctl_sync[1]) && (c_ff.ctl_sync[1] != c_ff.ctl_lvl);
  assign edge_ev = c_ff.edge_sync[1] != c_ff.edge_seen;
  assign mraz_done = c_ff.busy && (c_ff.mraz_cnt == mraz_c - CNT_ONE);

  // Channel words held between capture and frame build
  irc_result_mem u_mem (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_phase),
    .wr_addr(wr_off[CH_AW-1:0]),
    .wr_data(wr_word),
    .rd_addr(rd_off[CH_AW-1:0]),
    .rd_data(rd_word)
  );

  // System-clock next state
  always_comb begin
    nxt_c = c_ff;
    nxt_c.ctl_sync = {c_ff.ctl_sync[1:0], integration_control};
    nxt_c.fmt_sync = {c_ff.fmt_sync[1:0], word_select_20};
    nxt_c.fast_sync = {c_ff.fast_sync[1:0], fast_timing_sel};
    nxt_c.edge_sync = {c_ff.edge_sync[0], l_ff.edge_tgl};
    nxt_c.edge_seen = c_ff.edge_sync[1];
    if (ctl_ev) begin
      nxt_c.ctl_lvl = c_ff.ctl_sync[1];
    end
    if (c_ff.fmt_sync[2] == c_ff.fmt_sync[1]) begin
      nxt_c.fmt_lvl = c_ff.fmt_sync[1];
    end
    if (c_ff.fast_sync[2] == c_ff.fast_sync[1]) begin
      nxt_c.fast_lvl = c_ff.fast_sync[1];
    end
    if (c_ff.int_cnt != CNT_SAT) begin
      nxt_c.int_cnt = c_ff.int_cnt + CNT_ONE;
    end
    // A negative shift-clock edge seen after ready fell releases it
    if (edge_ev) begin
      nxt_c.ready_n = 1'b1;
    end
    // Measure-reset-autozero engine, also paces the frame build
    if (c_ff.busy) begin
      nxt_c.mraz_cnt = c_ff.mraz_cnt + CNT_ONE;
      if (c_ff.mraz_cnt == wr_at) begin
        nxt_c.bits20 = c_ff.fmt_lvl;
      end
      // Channel 0 lands deepest, so it leaves first, MSB first
      if (shift_phase) begin
        if (c_ff.bits20) begin
          nxt_c.frame = {c_ff.frame[FRAME_W-WORD_W-1:0], rd_word};
        end else begin
          nxt_c.frame = {c_ff.frame[FRAME_W-SHORT_W-1:0], rd_word[WORD_W-1:TRUNC_BITS]};
        end
      end
      if (c_ff.mraz_cnt == commit_at) begin
        nxt_c.load_tgl = ~c_ff.load_tgl;
      end
      // Falling ready wins over a release in the same cycle
      if (c_ff.mraz_cnt == integration_control_c - CNT_ONE) begin
        nxt_c.ready_n = 1'b0;
      end
      if (mraz_done) begin
        nxt_c.busy = 1'b0;
        nxt_c.mraz_cnt = '0;
      end
    end
    // Integration sequencer
    unique case (c_ff.st)
      ST_RELEASE: begin
        if (ctl_ev) begin
          nxt_c.st = ST_INTEG;
          nxt_c.seamless = 1'b0;
          nxt_c.second = 1'b0;
          nxt_c.int_cnt = '0;
        end
      end
      ST_INTEG: begin
        if (ctl_ev && c_ff.busy) begin
          // Previous side still measuring: period too short, go gapped
          nxt_c.seamless = 1'b0;
          nxt_c.pend = 1'b1;
          nxt_c.short_in = 1'b1;
          nxt_c.second = 1'b0;
          nxt_c.st = ST_GAP_WAIT;
        end else if (ctl_ev) begin
          nxt_c.busy = 1'b1;
          nxt_c.mraz_cnt = '0;
          nxt_c.side = ~c_ff.side;
          nxt_c.int_cnt = '0;
          // A long enough period restores seamless integration
          if (c_ff.seamless || (c_ff.int_cnt >= mraz_c)) begin
            nxt_c.seamless = 1'b1;
          end else if (!c_ff.second) begin
            nxt_c.second = 1'b1;
          end else begin
            nxt_c.second = 1'b0;
            nxt_c.short_in = 1'b1;
            nxt_c.st = ST_GAP_WAIT;
          end
        end
      end
      ST_GAP_WAIT: begin
        // Control edges are dropped until both sides are measured
        if (!c_ff.busy && c_ff.pend) begin
          nxt_c.busy = 1'b1;
          nxt_c.mraz_cnt = '0;
          nxt_c.pend = 1'b0;
        end else if (!c_ff.busy) begin
          nxt_c.st = ST_GAP_IDLE;
        end
      end
      ST_GAP_IDLE: begin
        if (ctl_ev) begin
          nxt_c.st = ST_INTEG;
          nxt_c.short_in = 1'b0;
          nxt_c.int_cnt = '0;
        end
      end
    endcase
  end

  // System-clock registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      c_ff <= '0;
      c_ff.st <= ST_RELEASE;
      c_ff.seamless <= RST_SEAMLESS;
      c_ff.ready_n <= RST_READY_N;
    end else begin
      c_ff <= nxt_c;
    end
  end

  // Frame is quasi-static: it changes only while the host keeps shift_clock idle
  assign new_frame = l_ff.seen_tgl != c_ff.load_tgl;

  // Shift-clock next state: one bit per falling edge, chain input fills behind
  always_comb begin
    nxt_l = l_ff;
    nxt_l.edge_tgl = ~l_ff.edge_tgl;
    nxt_l.seen_tgl = c_ff.load_tgl;
    if (new_frame) begin
      nxt_l.shreg = {c_ff.frame[FRAME_W-2:0], chain_in};
    end else begin
      nxt_l.shreg = {l_ff.shreg[FRAME_W-2:0], chain_in};
    end
    // Effective length 160 or 128 bits per device
    if (c_ff.bits20) begin
      nxt_l.dout = nxt_l.shreg[FRAME_W-1];
    end else begin
      nxt_l.dout = nxt_l.shreg[FRAME_SHORT-1];
    end
  end

  // Link-side registers; reset is asynchronous because this clock may be still
  always_ff @(negedge shift_clock or negedge resetn) begin
    if (!resetn) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // Before the first edge of a frame its first bit is shown straight from the frame
  assign serial_out = new_frame ? (c_ff.bits20 ? c_ff.frame[FRAME_W-1] : c_ff.frame[FRAME_SHORT-1]) : l_ff.dout;
  assign data_ready_n = c_ff.ready_n;
  assign integrating_side = c_ff.side;
  assign input_shorted = c_ff.short_in;
  assign seamless_mode = c_ff.seamless;

endmodule

`default_nettype wire

/* File: irc_pkg.sv */
// Shared constants and types for the integrator readout chain.
// Assumes a 25 MHz system clock; times are held in ns and turned into cycle counts here.
package irc_pkg;

  // System clock rate
  localparam int CLK_MHZ = 25;

  // Channel and word geometry
  localparam int NUM_CH = 8;
  localparam int CH_AW = 3;
  localparam int WORD_W = 20;
  localparam int SHORT_W = 16;
  localparam int TRUNC_BITS = 4;
  localparam int RAW_W = 24;
  localparam int FRAME_W = NUM_CH * WORD_W;
  localparam int FRAME_SHORT = NUM_CH * SHORT_W;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] BUILD_SLOTS = 16'h0008;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_SAT = 16'hFFFF;

  // Offset-binary output codes
  localparam logic [WORD_W-1:0] CODE_ZERO = 20'h0_1000;
  localparam logic [WORD_W-1:0] CODE_MAX = 20'hF_FFFF;
  localparam logic [WORD_W-1:0] CODE_MIN = 20'h0_0000;

  // Reset values
  localparam logic RST_READY_N = 1'b1;
  localparam logic RST_SEAMLESS = 1'b0;

  // Conversion and reset times in ns, normal and fast settings
  localparam int T_INTEGRATION_CONTROL_NS = 169_500;
  localparam int T_INTEGRATION_CONTROL_FAST_NS = 141_250;
  localparam int T_ADRST_NS = 4_000;
  localparam int T_ADRST_FAST_NS = 3_333;
  localparam int T_INTRST_NS = 23_000;
  localparam int T_INTRST_FAST_NS = 19_167;
  localparam int T_LEAD_NS = 1_750;
  localparam int T_LEAD_FAST_NS = 1_458;

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Derived cycle counts
  localparam int INTEGRATION_CONTROL_CYC_DEF = cyc_up(T_INTEGRATION_CONTROL_NS);
  localparam int INTEGRATION_CONTROL_FAST_CYC_DEF = cyc_up(T_INTEGRATION_CONTROL_FAST_NS);
  localparam int MRAZ_CYC_DEF = cyc_up(T_INTEGRATION_CONTROL_NS + T_ADRST_NS + T_INTRST_NS);
  localparam int MRAZ_FAST_CYC_DEF = cyc_up(T_INTEGRATION_CONTROL_FAST_NS + T_ADRST_FAST_NS + T_INTRST_FAST_NS);
  localparam logic [CNT_W-1:0] LEAD_CYC = CNT_W'(cyc_up(T_LEAD_NS));
  localparam logic [CNT_W-1:0] LEAD_FAST_CYC = CNT_W'(cyc_up(T_LEAD_FAST_NS));

  // Sequencer states
  typedef enum logic [1:0] {ST_RELEASE, ST_INTEG, ST_GAP_WAIT, ST_GAP_IDLE} irc_state_t;

  // Front-end results, one signed raw value per channel, one code step per LSB
  typedef struct packed {
    logic [NUM_CH-1:0][RAW_W-1:0] raw;
  } irc_results_t;

  // System-clock state of the top module
  typedef struct packed {
    logic [2:0] ctl_sync;
    logic [2:0] fmt_sync;
    logic [2:0] fast_sync;
    logic [1:0] edge_sync;
    logic edge_seen;
    logic ctl_lvl;
    logic fmt_lvl;
    logic fast_lvl;
    irc_state_t st;
    logic seamless;
    logic second;
    logic side;
    logic pend;
    logic short_in;
    logic busy;
    logic [CNT_W-1:0] mraz_cnt;
    logic [CNT_W-1:0] int_cnt;
    logic bits20;
    logic [FRAME_W-1:0] frame;
    logic load_tgl;
    logic ready_n;
  } irc_core_t;

  // Shift-clock state of the top module
  typedef struct packed {
    logic seen_tgl;
    logic edge_tgl;
    logic [FRAME_W-1:0] shreg;
    logic dout;
  } irc_link_t;

  // Result memory state
  typedef struct packed {
    logic [NUM_CH-1:0][WORD_W-1:0] mem;
    logic [WORD_W-1:0] rdata;
  } irc_mem_t;

endpackage

/* File: irc_result_mem.sv */
// Eight-word result store with one write port and a registered read port.
// Assumes writer and reader never address it in the same cycle of interest.
`timescale 1ns/1ps
`default_nettype none

module irc_result_mem
  import irc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write port
  input wire logic wr_en,
  input wire logic [CH_AW-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data,
  // Read port
  input wire logic [CH_AW-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data
);

  irc_mem_t m_ff;
  irc_mem_t nxt_m;

  // Write on strobe; read data always one cycle behind the address
  always_comb begin
    nxt_m = m_ff;
    if (wr_en) begin
      nxt_m.mem[wr_addr] = wr_data;
    end
    nxt_m.rdata = m_ff.mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      m_ff <= '0;
    end else begin
      m_ff <= nxt_m;
    end
  end

  assign rd_data = m_ff.rdata;

endmodule

`default_nettype wire

/* File: irc_readout_chain_asserts.sv */
// Port-level assertions for the readout chain.
// Assumes a bind to irc_readout_chain with its cycle parameters.
`timescale 1ns/1ps
`default_nettype none
module irc_readout_chain_asserts
  import irc_pkg::*;
#(
  parameter int INTEGRATION_CONTROL_CYC = INTEGRATION_CONTROL_CYC_DEF,
  parameter int INTEGRATION_CONTROL_FAST_CYC = INTEGRATION_CONTROL_FAST_CYC_DEF,
  parameter int MRAZ_CYC = MRAZ_CYC_DEF,
  parameter int MRAZ_FAST_CYC = MRAZ_FAST_CYC_DEF
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic shift_clock,
  // Host pins
  input wire logic integration_control,
  input wire logic word_select_20,
  input wire logic fast_timing_sel,
  input wire logic chain_in,
  input wire logic serial_out,
  input wire logic data_ready_n,
  // Front end
  input wire irc_results_t results,
  input wire logic integrating_side,
  input wire logic input_shorted,
  input wire logic seamless_mode
);
  logic f_tgl_ff;
  logic [2:0] f_sync_ff;
  logic [15:0] since_fall_ff;
  logic [15:0] since_out_ff;
  logic [15:0] since_side_ff;
  logic ctl_moved_ff;
  logic fall_ev;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic [15:0] sat(input logic [15:0] c);
    return (c == 16'hFFFF) ? c : c + 16'h0001;
  endfunction

  // Shift pulses are shorter than a system period, so toggle and sync
  always_ff @(negedge shift_clock or negedge resetn) begin
    if (!resetn) f_tgl_ff <= 1'b0;
    else f_tgl_ff <= ~f_tgl_ff;
  end

  assign fall_ev = f_sync_ff[2] ^ f_sync_ff[1];

  // Cycle counts since shift falls, output changes and side changes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      f_sync_ff <= 3'h0;
      since_fall_ff <= 16'hFFFF;
      since_out_ff <= 16'h0000;
      since_side_ff <= 16'h0000;
      ctl_moved_ff <= 1'b0;
    end else begin
      f_sync_ff <= {f_sync_ff[1:0], f_tgl_ff};
      since_fall_ff <= fall_ev ? 16'h0000 : sat(since_fall_ff);
      since_out_ff <= $changed(serial_out) ? 16'h0000 : sat(since_out_ff);
      since_side_ff <= $changed(integrating_side) ? 16'h0000 : sat(since_side_ff);
      ctl_moved_ff <= ctl_moved_ff | $changed(integration_control);
    end
  end

  property p_reset_vals;
    $rose(resetn) |-> data_ready_n && !seamless_mode && !input_shorted && !integrating_side;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values");
  property p_ready_rise;
    $rose(data_ready_n) |-> since_fall_ff <= 16'h0008;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready released without shift fall");
  property p_ready_release;
    fall_ev && !data_ready_n |-> ##[0:6] data_ready_n;
  endproperty
  a_ready_release: assert property (p_ready_release) else $error("ready not released");
  property p_lead;
    $fell(data_ready_n) |-> since_out_ff + 16'h0002 >= (fast_timing_sel ? LEAD_FAST_CYC : LEAD_CYC);
  endproperty
  a_lead: assert property (p_lead) else $error("first bit lead too short");
  property p_fallback;
    $fell(seamless_mode) |-> ##[0:2] input_shorted;
  endproperty
  a_fallback: assert property (p_fallback) else $error("input not shorted on fallback");
  property p_release;
    !ctl_moved_ff |-> data_ready_n && !input_shorted && !integrating_side;
  endproperty
  a_release: assert property (p_release) else $error("activity before first control edge");
  property p_drop;
    $fell(seamless_mode) |-> since_side_ff < 16'(MRAZ_CYC + 8);
  endproperty
  a_drop: assert property (p_drop) else $error("fallback outside a running measurement");
  property p_out_cause;
    $changed(serial_out) |-> (##[0:6] fall_ev) or (##[0:60] !data_ready_n);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("serial output moved without cause");
endmodule
`default_nettype wire

/* File: irc_host_model.sv */
// Host side of the link: makes the 64 ns shift clock only within a readout.
// Assumes the bench calls read_bits once data is ready.
`timescale 1ns/1ps
`default_nettype none
module irc_host_model (
  // Device pins
  input wire logic serial_out,
  output logic shift_clock,
  output logic chain_in,
  // Captured stream, last bit in bit 0
  output logic [167:0] got
);
  // Idle levels
  initial begin
    shift_clock = 1'b0;
    chain_in = 1'b0;
    got = '0;
  end

  // Upstream bits alternate, 1 at edge 1, so a shifted copy is easy to spot
  task automatic read_bits(input int n);
    got = '0;
    chain_in = 1'b1;
    for (int k = 1; k <= n; k++) begin
      #16 got = {got[166:0], serial_out};
      shift_clock = 1'b1;
      #32 shift_clock = 1'b0;
      #1 chain_in = ~k[0];
      #15;
    end
    chain_in = ~chain_in;
  endtask
endmodule
`default_nettype wire

/* File: irc_readout_chain_tb_top.sv */
// Testbench for the readout chain: gapped, seamless and fallback traffic.
// Assumes shortened conversion and measurement counts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module irc_readout_chain_tb_top
  import irc_pkg::*;
;
  localparam int INTEGRATION_CONTROL = 80;
  localparam int INTEGRATION_CONTROL_FAST = 70;
  localparam int MRAZ = 400;
  // Guard around control edges, scaled down with the shortened conversion
  localparam int GUARD = 10;
  logic clk = 1'b0;
  // Left unknown at first so the link flops see a real falling reset edge
  logic resetn;
  logic shift_clock, chain_in, serial_out, data_ready_n;
  logic integration_control = 1'b0;
  logic word_select_20 = 1'b0;
  logic fast_timing_sel = 1'b0;
  logic integrating_side, input_shorted, seamless_mode;
  logic [167:0] got;
  irc_results_t results;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_ctl = 0;
  int last_shift = 0;

  irc_readout_chain #(.INTEGRATION_CONTROL_CYC(INTEGRATION_CONTROL), .INTEGRATION_CONTROL_FAST_CYC(INTEGRATION_CONTROL_FAST), .MRAZ_CYC(MRAZ), .MRAZ_FAST_CYC(MRAZ)) u_dut (
    .clk(clk), .resetn(resetn), .shift_clock(shift_clock), .integration_control(integration_control),
    .word_select_20(word_select_20), .fast_timing_sel(fast_timing_sel), .chain_in(chain_in),
    .serial_out(serial_out), .data_ready_n(data_ready_n), .results(results),
    .integrating_side(integrating_side), .input_shorted(input_shorted), .seamless_mode(seamless_mode));
  irc_host_model u_host (.serial_out(serial_out), .shift_clock(shift_clock), .chain_in(chain_in), .got(got));

  // System clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Control edges only with shift_clock idle for the guard time
  task automatic ctl_toggle(input int n);
    while (cyc - last_shift < GUARD) begin
      tick(1);
    end
    last_ctl = cyc;
    integration_control = ~integration_control;
    tick(n);
  endtask

  // Offset binary with saturation and clipping
  function automatic logic [19:0] exp_code(input logic [23:0] r);
    int v;
    v = int'($signed(r)) + int'(CODE_ZERO);
    if (v < 0) return CODE_MIN;
    if (v > int'(CODE_MAX)) return CODE_MAX;
    return v[19:0];
  endfunction

  // Wait for data, read one frame plus eight upstream bits, judge all of it
  task automatic sc_read(input logic w20);
    logic [159:0] ef;
    logic [19:0] w;
    int t;
    ef = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      w = exp_code(results.raw[ch]);
      ef = w20 ? {ef[139:0], w} : {ef[143:0], w[19:4]};
    end
    t = 0;
    while (data_ready_n !== 1'b0 && t < 1500) begin
      tick(1);
      t++;
    end
    tick(3);
    `CHK("ready_hold", 1'b0, data_ready_n)
    // Stay clear of the last control edge, then finish before the next result
    while (cyc - last_ctl < GUARD) begin
      tick(1);
    end
    u_host.read_bits(w20 ? 168 : 136);
    last_shift = cyc;
    `CHK("frame", ef, got[167:8])
    `CHK("chain", 8'hAA, got[7:0])
    tick(8);
    `CHK("ready_rel", 1'b1, data_ready_n)
  endtask

  task automatic sc_power_up();
    `CHK("seamless", 1'b0, seamless_mode)
    // Host settling wait of 50 us before the first control edge
    tick(1250);
    `CHK("no_ready", 1'b1, data_ready_n)
    word_select_20 = 1'b1;
  endtask

  // Short pair, a control edge inside the wait, then both results
  task automatic sc_gapped();
    logic s;
    ctl_toggle(60);
    ctl_toggle(60);
    ctl_toggle(10);
    `CHK("shorted", 1'b1, input_shorted)
    s = integrating_side;
    ctl_toggle(10);
    `CHK("ignored", s, integrating_side)
    sc_read(1'b1);
    sc_read(1'b1);
  endtask

  // Long integrations with 16-bit words
  task automatic sc_seamless();
    word_select_20 = 1'b0;
    // Gapped pair must be fully measured, else the next edge is dropped
    tick(MRAZ);
    ctl_toggle(500);
    for (int i = 0; i < 3; i++) begin
      ctl_toggle(90);
      sc_read(1'b0);
      tick(200);
    end
    `CHK("seamless", 1'b1, seamless_mode)
    `CHK("open", 1'b0, input_shorted)
  endtask

  // Control edge inside a running measurement
  task automatic sc_fallback();
    // Fast timing set, changed while no measurement runs
    fast_timing_sel = 1'b1;
    ctl_toggle(100);
    ctl_toggle(10);
    `CHK("gapped", 1'b0, seamless_mode)
    `CHK("shorted", 1'b1, input_shorted)
    sc_read(1'b0);
    sc_read(1'b0);
  endtask

  // Main sequence
  initial begin
    results.raw = {24'h01_2345, 24'h0F_F000, 24'h0F_EFFF, 24'h7F_FFFF,
                   24'h00_0001, 24'hFF_EC78, 24'hFF_F000, 24'h00_0000};
    #1 resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    tick(1);
    sc_power_up();
    sc_gapped();
    sc_seamless();
    sc_fallback();
    give_verdict();
  end
endmodule

bind irc_readout_chain irc_readout_chain_asserts #(.INTEGRATION_CONTROL_CYC(INTEGRATION_CONTROL_CYC), .INTEGRATION_CONTROL_FAST_CYC(INTEGRATION_CONTROL_FAST_CYC),
  .MRAZ_CYC(MRAZ_CYC), .MRAZ_FAST_CYC(MRAZ_FAST_CYC)) u_chk (
  .clk(clk), .resetn(resetn), .shift_clock(shift_clock), .integration_control(integration_control),
  .word_select_20(word_select_20), .fast_timing_sel(fast_timing_sel), .chain_in(chain_in),
  .serial_out(serial_out), .data_ready_n(data_ready_n), .results(results),
  .integrating_side(integrating_side), .input_shorted(input_shorted), .seamless_mode(seamless_mode));
`default_nettype wire
